// ==== pkg/ble_cfg_pkg.sv ====
// constants of the link-layer control and identification bank
// assumes a single 25 MHz clock and a plain strobed register port
// Function
// - cipher_off stops payload encryption and decryption
// - descriptor cipher keeps integrity code, plain payload
// - whitening_off set bypasses data whitening
// - crc_keep keeps rx crc, zeroes tx crc
// - hop_remap_off disables channel remapping
// - adv filter drops only errored advertising packets
// - exchange_prefetch_on enables exchange table prefetch
// - rx window used by connected master, second receipt
// - sync word accepted within error limit
// - version register read-only, four byte fields
// - address width field reads fixed value
// - radio id and clock frequency read-only
// - present_a and dual-mode bits read zero
// - level interrupt flag reads one
// - coexistence, diag, ccm, bus width read one
package ble_cfg_pkg;
  localparam int ADDR_W = 32; // bus address width
  localparam int DATA_W = 32; // bus data width
  // byte addresses of the bank
  localparam logic [31:0] OFF_CTRL = 32'h4000_0000;
  localparam logic [31:0] OFF_VER  = 32'h4000_0004;
  localparam logic [31:0] OFF_CONF = 32'h4000_0008;
  // control field positions
  localparam int CIPHER_OFF_BIT = 19;
  localparam int WHIT_OFF_BIT   = 18;
  localparam int CRC_KEEP_BIT   = 17;
  localparam int REMAP_OFF_BIT  = 16;
  localparam int ADV_FILT_BIT   = 9;
  localparam int PREFETCH_BIT   = 8;
  localparam int RXWIN_LSB      = 4;
  localparam int RXWIN_W        = 4;
  localparam int SYNC_LSB       = 0;
  localparam int SYNC_W         = 3;
  localparam logic [31:0] CTRL_WMASK = 32'h000F_03F7; // writable bits
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000; // reset value
  // version field positions
  localparam int VER_TYPE_LSB  = 24;
  localparam int VER_MAJOR_LSB = 16;
  localparam int VER_UPG_LSB   = 8;
  localparam int VER_BUILD_LSB = 0;
  // build configuration fields
  localparam logic [5:0] CONF_ADDR_WIDTH = 6'h0F;
  localparam logic [6:0] CONF_RADIO_ID   = 7'h02;
  localparam logic [5:0] CONF_CLK_MHZ    = 6'h00;
  localparam logic [6:0] CONF_FEATURES   = 7'h1F; // bits 6..0
  localparam logic [31:0] CONF_WORD = {2'h0, CONF_ADDR_WIDTH, 1'h0,
    CONF_RADIO_ID, 2'h0, CONF_CLK_MHZ, 1'h0, CONF_FEATURES};
  // datapath widths and fills
  localparam int CRC_W   = 24;
  localparam int SYNCE_W = 6;
  localparam logic [23:0] CRC_TX_FILL = 24'h00_0000;
endpackage

// ==== pkg/ctrl_if.sv ====
// control fields carried from the register bank to the policy unit
// assumes both ends sit in the same clock domain
`timescale 1ns/10ps
`default_nettype none
interface ctrl_if;
  logic       cipher_off;            // payload cipher stopped
  logic       whitening_off;         // whitening bypassed
  logic       crc_keep;              // crc kept on rx
  logic       hop_remap_off;         // remapping stopped
  logic       adv_error_filter_on;   // advertising error filter
  logic       exchange_prefetch_on;  // prefetch enabled
  logic [3:0] default_rx_window;     // window in microseconds
  logic [2:0] sync_word_error_limit; // allowed sync bit errors
  modport src (output cipher_off, whitening_off, crc_keep,
    hop_remap_off, adv_error_filter_on, exchange_prefetch_on,
    default_rx_window, sync_word_error_limit);
  modport snk (input cipher_off, whitening_off, crc_keep,
    hop_remap_off, adv_error_filter_on, exchange_prefetch_on,
    default_rx_window, sync_word_error_limit);
endinterface
`default_nettype wire

// ==== test/ble_core_regs_tb.sv ====
// self-checking bench for the control and identification bank
// assumes reads answer one cycle later and the bank never stalls
`timescale 1ns/10ps
`default_nettype none
module ble_core_regs_tb
  import ble_cfg_pkg::*;
;
  logic        ref_clk, rst_b;           // clock and reset
  logic [31:0] bus_addr, bus_wdata;      // bus request
  logic [31:0] bus_rdata;                // bus answer
  logic        bus_wr, bus_rd;           // bus strobes
  logic        desc_cipher, rx_done;     // datapath stimulus
  logic        rx_err, rx_on_adv;        // reception qualifiers
  logic        sync_check;               // sync compare pulse
  logic        conn_master, second_rx;   // window qualifiers
  logic [23:0] tx_crc_in, tx_crc_out;    // crc in and out
  logic [5:0]  sync_errs;                // sync bit errors
  logic        payload_cipher, mic_gen;  // cipher controls
  logic        whiten_en, crc_strip;     // whitening and crc
  logic        remap_en, prefetch_en;    // remap and prefetch
  logic        rx_report, rx_win_use;    // report and window
  logic        sync_hit;                 // sync recognised
  logic [3:0]  rx_win_us;                // window length
  logic [31:0] ver_exp, conf_exp;        // expected id words
  int          error_cnt, n_tests, cyc_cnt; // bookkeeping
  // id values are arbitrary
  ble_core_regs #(.CORE_TYPE(8'hC3), .MAJOR_RELEASE(8'h1E),
    .UPGRADE_NUM(8'h6B), .BUILD_NUM(8'h91)) dut_u (.ref_clk(ref_clk),
    .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .desc_cipher(desc_cipher), .rx_done(rx_done), .rx_err(rx_err),
    .rx_on_adv(rx_on_adv), .tx_crc_in(tx_crc_in),
    .sync_check(sync_check), .sync_errs(sync_errs),
    .conn_master(conn_master), .second_rx(second_rx),
    .payload_cipher(payload_cipher), .mic_gen(mic_gen),
    .whiten_en(whiten_en), .crc_strip(crc_strip),
    .tx_crc_out(tx_crc_out), .remap_en(remap_en),
    .prefetch_en(prefetch_en), .rx_report(rx_report),
    .rx_win_use(rx_win_use), .rx_win_us(rx_win_us),
    .sync_hit(sync_hit));
  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // prints verdict and stops
  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compares a register read
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t read %h want %h", $time, got, exp);
    end
  endtask
  // compares a datapath output
  task automatic cmp_out(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t output %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write, strobe left for the next call to drop
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_rd    <= 1'b0;
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus_wr   <= 1'b0;
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 cmp_word(bus_rdata, exp);
  endtask
  // writes control and waits until outputs follow
  task automatic setctl(input logic [31:0] d);
    wr(OFF_CTRL, d);
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  // one reception pulse, report checked then cleared
  task automatic rx_case(input logic e, input logic a, input logic x);
    @(posedge ref_clk);
    rx_done   <= 1'b1;
    rx_err    <= e;
    rx_on_adv <= a;
    @(posedge ref_clk);
    rx_done <= 1'b0;
    #1 cmp_out(24'(rx_report), 24'(x));
    @(posedge ref_clk);
    #1 cmp_out(24'(rx_report), 24'h00_0000);
  endtask
  // one sync compare pulse
  task automatic sync_case(input logic [5:0] n, input logic x);
    @(posedge ref_clk);
    sync_check <= 1'b1;
    sync_errs  <= n;
    @(posedge ref_clk);
    sync_check <= 1'b0;
    #1 cmp_out(24'(sync_hit), 24'(x));
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  // main sequence
  initial
  begin
    {rst_b, bus_wr, bus_rd, desc_cipher, rx_done, rx_err} = 6'h00;
    {rx_on_adv, sync_check, conn_master, second_rx} = 4'h0;
    bus_addr  = 32'h0000_0000;
    bus_wdata = 32'h0000_0000;
    tx_crc_in = 24'hA5_C35A;
    sync_errs = 6'h00;
    error_cnt = 0;
    n_tests   = 0;
    cyc_cnt   = 0;
    ver_exp   = 32'hC31E_6B91;
    conf_exp  = {2'h0, 6'h0F, 1'h0, CONF_RADIO_ID, 2'h0, CONF_CLK_MHZ,
      1'h0, 7'h1F};
    repeat (5) @(posedge ref_clk);
    rst_b       <= 1'b1;
    desc_cipher <= 1'b1;
    @(posedge ref_clk);
    #1 cmp_out(24'(whiten_en), 24'h00_0001);
    cmp_out(24'(crc_strip), 24'h00_0001);
    cmp_out(tx_crc_out, 24'hA5_C35A);
    cmp_out(24'(remap_en), 24'h00_0001);
    cmp_out(24'(payload_cipher), 24'h00_0001);
    rd(OFF_CTRL, 32'h0000_0000);
    rd(OFF_VER, ver_exp);
    rd(OFF_CONF, conf_exp);
    @(posedge ref_clk);
    #1 cmp_word(bus_rdata, 32'h0000_0000);
    // read-only and unmapped places, back to back
    wr(OFF_VER, 32'hFFFF_FFFF);
    wr(OFF_CONF, 32'hFFFF_FFFF);
    wr(32'h4000_000C, 32'hFFFF_FFFF);
    rd(OFF_VER, ver_exp);
    rd(OFF_CONF, conf_exp);
    rd(32'h4000_000C, 32'h0000_0000);
    rd(OFF_CTRL, 32'h0000_0000);
    // every control bit set
    setctl(32'hFFFF_FFFF);
    cmp_out(24'(payload_cipher), 24'h00_0000);
    cmp_out(24'(mic_gen), 24'h00_0001);
    cmp_out(24'(whiten_en), 24'h00_0000);
    cmp_out(24'(crc_strip), 24'h00_0000);
    cmp_out(tx_crc_out, 24'h00_0000);
    cmp_out(24'(remap_en), 24'h00_0000);
    cmp_out(24'(prefetch_en), 24'h00_0001);
    cmp_out(24'(rx_win_us), 24'h00_000F);
    rd(OFF_CTRL, 32'h000F_03F7);
    // every control bit clear except rx window 0xA, cipher descriptor off
    desc_cipher <= 1'b0;
    setctl(32'h0000_00A0);
    cmp_out(24'(mic_gen), 24'h00_0000);
    cmp_out(24'(payload_cipher), 24'h00_0000);
    cmp_out(tx_crc_out, 24'hA5_C35A);
    cmp_out(24'(prefetch_en), 24'h00_0000);
    // error filter over all qualifier combinations
    for (int f = 0; f < 2; f++)
    begin
      setctl((32'(f) << 9) | 32'h0000_00A0);
      for (int k = 0; k < 4; k++)
        rx_case(k[0], k[1], !(f[0] & k[0] & k[1]));
    end
    // sync error limit boundaries
    for (int l = 0; l < 8; l += 3)
    begin
      setctl(32'(l) | 32'h0000_00A0);
      sync_case(6'(l), 1'b1);
      sync_case(6'(l + 1), 1'b0);
    end
    // advised window value, used only as master on second receipt
    setctl(32'h0000_00A0);
    cmp_out(24'(rx_win_us), 24'h00_000A);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk);
      conn_master <= k[0];
      second_rx   <= k[1];
      @(posedge ref_clk);
      #1 cmp_out(24'(rx_win_use), 24'(k == 3));
    end
    // reset in mid-run clears control
    setctl(32'hFFFF_FFFF);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(OFF_CTRL, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== verilog/ble_core_regs.sv ====
// control and identification register bank of the link-layer core
// assumes software on a strobed port, read data one cycle later
`timescale 1ns/10ps
`default_nettype none
module ble_core_regs
  import ble_cfg_pkg::*;
#(
  // identification codes; values are arbitrary
  parameter logic [7:0] CORE_TYPE     = 8'h5A,
  parameter logic [7:0] MAJOR_RELEASE = 8'h02,
  parameter logic [7:0] UPGRADE_NUM   = 8'h03,
  parameter logic [7:0] BUILD_NUM     = 8'h04
)
(
  input  wire logic               ref_clk,     // core clock, 25 MHz
  input  wire logic               rst_b,       // async reset, low
  input  wire logic [ADDR_W-1:0]  bus_addr,    // byte address
  input  wire logic [DATA_W-1:0]  bus_wdata,   // write data
  input  wire logic               bus_wr,      // write strobe
  input  wire logic               bus_rd,      // read strobe
  output logic      [DATA_W-1:0]  bus_rdata,   // read data, next cycle
  input  wire logic               desc_cipher, // descriptor cipher on
  input  wire logic               rx_done,     // reception finished
  input  wire logic               rx_err,      // reception error
  input  wire logic               rx_on_adv,   // advertising channel
  input  wire logic [CRC_W-1:0]   tx_crc_in,   // computed tx crc
  input  wire logic               sync_check,  // sync word compared
  input  wire logic [SYNCE_W-1:0] sync_errs,   // sync bit errors
  input  wire logic               conn_master, // connected master
  input  wire logic               second_rx,   // second receipt
  output logic                    payload_cipher, // cipher payload
  output logic                    mic_gen,        // build integrity
  output logic                    whiten_en,      // whitening on
  output logic                    crc_strip,      // strip rx crc
  output logic      [CRC_W-1:0]   tx_crc_out,     // crc sent
  output logic                    remap_en,       // remapping on
  output logic                    prefetch_en,    // prefetch on
  output logic                    rx_report,      // report pulse
  output logic                    rx_win_use,     // window applies
  output logic      [RXWIN_W-1:0] rx_win_us,      // window length
  output logic                    sync_hit        // sync recognised
);
  // stored control word, only writable bits ever set
  logic [DATA_W-1:0] ctrl_r;
  // read data register
  logic [DATA_W-1:0] rdata_r;
  // combinational read mux value
  logic [DATA_W-1:0] rdata_nxt;
  // fixed version word
  logic [DATA_W-1:0] ver_word;
  // decoded selects
  logic              sel_ctrl;
  logic              sel_ver;
  logic              sel_conf;

  // fields carried to the policy unit
  ctrl_if cfg ();

  // version word built from identification parameters
  assign ver_word = (32'(CORE_TYPE)     << VER_TYPE_LSB)
                  | (32'(MAJOR_RELEASE) << VER_MAJOR_LSB)
                  | (32'(UPGRADE_NUM)   << VER_UPG_LSB)
                  | (32'(BUILD_NUM)     << VER_BUILD_LSB);

  // address decode, full word compare
  assign sel_ctrl = (bus_addr == OFF_CTRL);
  assign sel_ver  = (bus_addr == OFF_VER);
  assign sel_conf = (bus_addr == OFF_CONF);

  // control register write; read-only words ignore writes
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      ctrl_r <= CTRL_RST;
    else if (bus_wr && sel_ctrl)
      ctrl_r <= bus_wdata & CTRL_WMASK;

  // read mux; unmapped addresses and reserved bits give zero
  always_comb
  begin
    rdata_nxt = '0;
    if (bus_rd)
    begin
      if (sel_ctrl)
        rdata_nxt = ctrl_r & CTRL_WMASK;
      else if (sel_ver)
        rdata_nxt = ver_word;
      else if (sel_conf)
        rdata_nxt = CONF_WORD;
      else
        rdata_nxt = '0; // unmapped
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      rdata_r <= '0;
    else
      rdata_r <= rdata_nxt;

  assign bus_rdata = rdata_r;

  // control fields onto the carrier
  assign cfg.cipher_off    = ctrl_r[CIPHER_OFF_BIT];
  assign cfg.whitening_off = ctrl_r[WHIT_OFF_BIT];
  assign cfg.crc_keep      = ctrl_r[CRC_KEEP_BIT];
  assign cfg.hop_remap_off = ctrl_r[REMAP_OFF_BIT];
  assign cfg.adv_error_filter_on  = ctrl_r[ADV_FILT_BIT];
  assign cfg.exchange_prefetch_on = ctrl_r[PREFETCH_BIT];
  assign cfg.default_rx_window =
    ctrl_r[RXWIN_LSB +: RXWIN_W];
  assign cfg.sync_word_error_limit =
    ctrl_r[SYNC_LSB +: SYNC_W];

  // registered datapath controls
  link_policy u_policy (
    .ref_clk          (ref_clk),
    .rst_b            (rst_b),
    .cfg              (cfg),
    .desc_cipher      (desc_cipher),
    .rx_done          (rx_done),
    .rx_err           (rx_err),
    .rx_on_adv        (rx_on_adv),
    .tx_crc_in        (tx_crc_in),
    .sync_check       (sync_check),
    .sync_errs        (sync_errs),
    .conn_master      (conn_master),
    .second_rx        (second_rx),
    .payload_cipher_r (payload_cipher),
    .mic_gen_r        (mic_gen),
    .whiten_en_r      (whiten_en),
    .crc_strip_r      (crc_strip),
    .tx_crc_out_r     (tx_crc_out),
    .remap_en_r       (remap_en),
    .prefetch_en_r    (prefetch_en),
    .rx_report_r      (rx_report),
    .rx_win_use_r     (rx_win_use),
    .rx_win_us_r      (rx_win_us),
    .sync_hit_r       (sync_hit)
  );

  // checks, all on the core clock
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // version word read back whole
  version_read_a: assert property (
    bus_rd && sel_ver |=> bus_rdata[31:24] == CORE_TYPE
      && bus_rdata[23:16] == MAJOR_RELEASE
      && bus_rdata[15:8] == UPGRADE_NUM
      && bus_rdata[7:0] == BUILD_NUM)
    else $error("version read wrong");

  // address width field fixed
  addr_width_a: assert property (
    bus_rd && sel_conf |=> bus_rdata[29:24] == CONF_ADDR_WIDTH)
    else $error("address width field wrong");

  // radio id and clock fields
  radio_clock_a: assert property (
    bus_rd && sel_conf |=> bus_rdata[22:16] == CONF_RADIO_ID
      && bus_rdata[13:8] == CONF_CLK_MHZ)
    else $error("radio or clock field wrong");

  // absent features read zero
  absent_feat_a: assert property (
    bus_rd && sel_conf |=> !bus_rdata[6] && !bus_rdata[5])
    else $error("absent feature bit set");

  // level interrupt flag
  level_irq_a: assert property (
    bus_rd && sel_conf |=> bus_rdata[4])
    else $error("level interrupt flag clear");

  // present features and bus width
  present_feat_a: assert property (
    bus_rd && sel_conf |=> bus_rdata[3:0] == 4'hF)
    else $error("present feature bit clear");

  // reserved control bits never read back
  reserved_zero_a: assert property (
    bus_rd && sel_ctrl |=> (bus_rdata & ~CTRL_WMASK) == '0)
    else $error("reserved control bit read one");

  // write to read-only word leaves control alone
  ro_write_a: assert property (
    bus_wr && !sel_ctrl |=> ctrl_r == $past(ctrl_r))
    else $error("read-only write changed control");

  // read data present only right after a read
  read_window_a: assert property (
    !bus_rd |=> bus_rdata == '0)
    else $error("read data outside its cycle");

  // cipher off blocks payload cipher two cycles on
  cipher_off_a: assert property (
    bus_wr && sel_ctrl && bus_wdata[CIPHER_OFF_BIT]
      ##1 cfg.cipher_off |=> !payload_cipher)
    else $error("payload ciphered while off");

  // integrity code still built with cipher off
  mic_kept_a: assert property (
    desc_cipher && cfg.cipher_off |=> mic_gen && !payload_cipher)
    else $error("integrity code dropped");

  // whitening follows its control
  whiten_ctrl_a: assert property (
    cfg.whitening_off |=> !whiten_en)
    else $error("whitening not bypassed");

  // crc kept and tx crc zeroed
  crc_keep_a: assert property (
    cfg.crc_keep |=> !crc_strip && tx_crc_out == CRC_TX_FILL)
    else $error("crc keep not applied");

  // crc passes through when stripping
  // not started on the release edge: outputs still reset there
  crc_pass_a: assert property (
    rst_b && !cfg.crc_keep |=> crc_strip
      && tx_crc_out == $past(tx_crc_in))
    else $error("tx crc altered");

  // remap follows its control
  remap_ctrl_a: assert property (
    cfg.hop_remap_off != $past(cfg.hop_remap_off)
      |=> remap_en == !$past(cfg.hop_remap_off))
    else $error("remap control ignored");

  // filtered errored advertising packet not reported
  adv_filter_a: assert property (
    rx_done && rx_err && rx_on_adv && cfg.adv_error_filter_on
      |=> !rx_report)
    else $error("errored packet reported");

  // unfiltered errors are reported
  adv_report_a: assert property (
    rx_done && !cfg.adv_error_filter_on |=> rx_report)
    else $error("error not reported");

  // prefetch follows its control
  prefetch_a: assert property (
    cfg.exchange_prefetch_on ##1 cfg.exchange_prefetch_on
      |-> prefetch_en)
    else $error("prefetch not enabled");

  // window offered on second receipt as master
  // not started on the release edge: outputs still reset there
  rx_window_a: assert property (
    rst_b && conn_master && second_rx |=> rx_win_use
      && rx_win_us == $past(cfg.default_rx_window))
    else $error("rx window not applied");

  // sync accepted only inside the limit
  sync_limit_a: assert property (
    sync_check |=> sync_hit == ($past(sync_errs)
      <= {3'h0, $past(cfg.sync_word_error_limit)}))
    else $error("sync decision wrong");
endmodule
`default_nettype wire

// ==== verilog/link_policy.sv ====
// policy unit: turns control fields into registered datapath controls
// assumes event inputs synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module link_policy
  import ble_cfg_pkg::*;
(
  input  wire logic               ref_clk,      // core clock
  input  wire logic               rst_b,        // async reset, low
  ctrl_if.snk                     cfg,          // control fields
  input  wire logic               desc_cipher,  // descriptor cipher on
  input  wire logic               rx_done,      // reception finished
  input  wire logic               rx_err,       // reception had error
  input  wire logic               rx_on_adv,    // advertising channel
  input  wire logic [CRC_W-1:0]   tx_crc_in,    // computed tx crc
  input  wire logic               sync_check,   // sync word compared
  input  wire logic [SYNCE_W-1:0] sync_errs,    // sync bit errors
  input  wire logic               conn_master,  // connected master
  input  wire logic               second_rx,    // second receipt
  output logic                    payload_cipher_r, // cipher payload
  output logic                    mic_gen_r,        // build integrity
  output logic                    whiten_en_r,      // whitening on
  output logic                    crc_strip_r,      // strip rx crc
  output logic [CRC_W-1:0]        tx_crc_out_r,     // crc sent
  output logic                    remap_en_r,       // remapping on
  output logic                    prefetch_en_r,    // prefetch on
  output logic                    rx_report_r,      // report pulse
  output logic                    rx_win_use_r,     // window applies
  output logic [RXWIN_W-1:0]      rx_win_us_r,      // window length
  output logic                    sync_hit_r        // sync recognised
);
  // cipher and integrity controls
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      payload_cipher_r <= 1'b0;
      mic_gen_r        <= 1'b0;
    end
    else
    begin
      payload_cipher_r <= desc_cipher & ~cfg.cipher_off;
      mic_gen_r        <= desc_cipher;
    end

  // framing controls: whitening, crc, remap, prefetch
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      whiten_en_r   <= 1'b0;
      crc_strip_r   <= 1'b0;
      tx_crc_out_r  <= CRC_TX_FILL;
      remap_en_r    <= 1'b0;
      prefetch_en_r <= 1'b0;
    end
    else
    begin
      whiten_en_r   <= ~cfg.whitening_off;
      crc_strip_r   <= ~cfg.crc_keep;
      tx_crc_out_r  <= cfg.crc_keep ? CRC_TX_FILL : tx_crc_in;
      remap_en_r    <= ~cfg.hop_remap_off;
      prefetch_en_r <= cfg.exchange_prefetch_on;
    end

  // reception reporting, window and sync decisions
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      rx_report_r  <= 1'b0;
      rx_win_use_r <= 1'b0;
      rx_win_us_r  <= '0;
      sync_hit_r   <= 1'b0;
    end
    else
    begin
      rx_report_r  <= rx_done & ~(cfg.adv_error_filter_on
                      & rx_on_adv & rx_err);
      rx_win_use_r <= conn_master & second_rx;
      rx_win_us_r  <= cfg.default_rx_window;
      sync_hit_r   <= sync_check & (sync_errs <=
                      {{(SYNCE_W-SYNC_W){1'b0}},
                       cfg.sync_word_error_limit});
    end
endmodule
`default_nettype wire
